// ### design/ext_irq_defs.vh
/*
 Constants shared by the external interrupt pin interface: vector
 numbers, power-down mode codes, reset values and sizes.
 Assumes it is included by bare name from each design file.
*/
`ifndef EXT_IRQ_DEFS_VH
`define EXT_IRQ_DEFS_VH

// Number of polarity-selectable external interrupt inputs
`define EXT_IRQ_COUNT 4
// Number of synchronised pins: four external inputs plus the nonmaskable one
`define SYNC_PIN_COUNT 5
// Position of the nonmaskable input in the synchronised pin vector
`define NMI_PIN_POS 4

// Service table indices (one fetch packet per vector)
`define VEC_RESET 4'h0
`define VEC_NMI 4'h1
`define VEC_EXT_BASE 4'h4

// Polarity select bit: 0 takes a rising edge, 1 a falling edge
`define POL_RISING 1'b0

// Power-down mode codes carried with a mode entry strobe
`define PD_MODE_NONE 2'h0
`define PD_MODE_1 2'h1
`define PD_MODE_2 2'h2
`define PD_MODE_3 2'h3

// Reset values
`define SYNC_RESET_LEVEL 1'b0
`define FLAGS_RESET 4'h0
`define SERVICED_IRQ_NUMBER_RESET 4'h0

`endif

// ### design/ext_irq_pin_interface.v
/*
 Pin-level interrupt interface: edge capture of four external
 interrupt inputs with per-input polarity, a nonmaskable input,
 service acknowledge and number outputs, and power-down status.
 Assumes the CPU core reports each serviced vector with a one-cycle
 strobe on the same clock, and supplies polarity, enable and
 power-down entry on the same clock.
*/
`timescale 1ns/1ns
`include "ext_irq_defs.vh"

module ext_irq_pin_interface (
   // Clock and reset
   input wire clock,
   input wire reset_n,
   // External interrupt pins
   input wire ext_irq_in_a,
   input wire ext_irq_in_b,
   input wire ext_irq_in_c,
   input wire ext_irq_in_d,
   input wire nmi_in,
   // Interrupt controls from the core
   input wire [3:0] ext_irq_polarity_sel,
   input wire [3:0] ext_irq_enable,
   // Service report from the core
   input wire cpu_service_strobe,
   input wire [3:0] cpu_service_vector,
   // Power-down entry from the core
   input wire pd_enter_strobe,
   input wire [1:0] pd_enter_mode,
   // Interrupt requests to the core
   output wire [3:0] ext_irq_req,
   output wire nmi_req,
   // Acknowledge pins
   output wire irq_service_ack,
   output wire [3:0] serviced_irq_number,
   // Power-down pins and status
   output wire deep_sleep_status,
   output wire cpu_run
);

   // Power-down states, one-hot
   localparam [3:0] ST_RUN = 4'b0001;
   localparam [3:0] ST_PD1 = 4'b0010;
   localparam [3:0] ST_PD2 = 4'b0100;
   localparam [3:0] ST_PD3 = 4'b1000;

   wire [`SYNC_PIN_COUNT-1:0] pin_vec;
   wire [`SYNC_PIN_COUNT-1:0] pin_rise;
   wire [`SYNC_PIN_COUNT-1:0] pin_fall;
   wire [3:0] ext_edge;
   wire [3:0] ext_clear;
   wire nmi_edge;
   wire nmi_clear;
   wire service_taken;
   wire wake_event;

   reg [3:0] ext_flag_r;
   reg [3:0] ext_flag_nxt;
   reg nmi_flag_r;
   reg nmi_flag_nxt;
   reg [3:0] ext_irq_req_r;
   reg nmi_req_r;
   reg irq_service_ack_r;
   reg [3:0] serviced_irq_number_r;
   reg [3:0] serviced_irq_number_nxt;
   reg [3:0] state_r;
   reg [3:0] state_nxt;
   reg deep_sleep_status_r;
   reg cpu_run_r;

   // True when a serviced vector matches a given table index
   function vec_hit;
      input [3:0] vector;
      input [3:0] index;
      begin
         vec_hit = (vector == index);
      end
   endfunction

   assign pin_vec = {nmi_in, ext_irq_in_d, ext_irq_in_c, ext_irq_in_b, ext_irq_in_a};

   // One synchroniser per pin; the pins are asynchronous to clock
   // Only the edge pulses matter here, so the stable level stays open
   genvar g;
   generate
      for (g = 0; g < `SYNC_PIN_COUNT; g = g + 1) begin : gen_sync
         pin_edge_sync u_sync (
            .clock(clock),
            .reset_n(reset_n),
            .pin(pin_vec[g]),
            .level(),
            .rise(pin_rise[g]),
            .fall(pin_fall[g])
         );
      end
   endgenerate

   // Polarity picks which edge counts; changing it never fakes an edge
   generate
      for (g = 0; g < `EXT_IRQ_COUNT; g = g + 1) begin : gen_edge
         assign ext_edge[g] = (ext_irq_polarity_sel[g] == `POL_RISING) ? pin_rise[g] : pin_fall[g];
         assign ext_clear[g] = service_taken & vec_hit(cpu_service_vector, `VEC_EXT_BASE + g[3:0]);
      end
   endgenerate

   // Nonmaskable input ignores polarity and every enable
   assign nmi_edge = pin_rise[`NMI_PIN_POS];
   assign nmi_clear = service_taken & vec_hit(cpu_service_vector, `VEC_NMI);

   // A halted core services nothing, so its reports are ignored in power-down
   assign service_taken = cpu_service_strobe & (state_r == ST_RUN);

   // Light sleep ends on any request the core would take
   assign wake_event = (|(ext_flag_r & ext_irq_enable)) | nmi_flag_r;

   // Pending flags; a new edge wins over a clear in the same cycle
   always @* begin
      ext_flag_nxt = ext_edge | (ext_flag_r & ~ext_clear);
      nmi_flag_nxt = nmi_edge | (nmi_flag_r & ~nmi_clear);
   end

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ext_flag_r <= `FLAGS_RESET;
         nmi_flag_r <= 1'b0;
      end else begin
         ext_flag_r <= ext_flag_nxt;
         nmi_flag_r <= nmi_flag_nxt;
      end
   end

   // Requests to the core; the maskable ones are gated, the NMI never is
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ext_irq_req_r <= `FLAGS_RESET;
         nmi_req_r <= 1'b0;
      end else begin
         ext_irq_req_r <= ext_flag_nxt & ext_irq_enable;
         nmi_req_r <= nmi_flag_nxt;
      end
   end

   // Number is loaded with each ack cycle and held after it, so it is
   // stable until the next service; back-to-back services change it every cycle
   always @* begin
      serviced_irq_number_nxt = serviced_irq_number_r;
      if (service_taken) begin
         serviced_irq_number_nxt = cpu_service_vector;
      end
   end

   // Acknowledge follows every service, whatever the source
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         irq_service_ack_r <= 1'b0;
         serviced_irq_number_r <= `SERVICED_IRQ_NUMBER_RESET;
      end else begin
         irq_service_ack_r <= service_taken;
         serviced_irq_number_r <= serviced_irq_number_nxt;
      end
   end

   // Power-down sequencing; modes 2 and 3 leave only through reset
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_RUN: begin
            if (pd_enter_strobe) begin
               if (pd_enter_mode == `PD_MODE_1) begin
                  state_nxt = ST_PD1;
               end else if (pd_enter_mode == `PD_MODE_2) begin
                  state_nxt = ST_PD2;
               end else if (pd_enter_mode == `PD_MODE_3) begin
                  state_nxt = ST_PD3;
               end
            end
         end
         ST_PD1: begin
            if (wake_event) begin
               state_nxt = ST_RUN;
            end
         end
         ST_PD2: begin
            state_nxt = ST_PD2;
         end
         ST_PD3: begin
            state_nxt = ST_PD3;
         end
         default: begin
            state_nxt = ST_RUN;
         end
      endcase
   end

   // Status pins follow the next state so they change with it
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= ST_RUN;
         deep_sleep_status_r <= 1'b0;
         cpu_run_r <= 1'b1;
      end else begin
         state_r <= state_nxt;
         deep_sleep_status_r <= (state_nxt == ST_PD2) | (state_nxt == ST_PD3);
         cpu_run_r <= (state_nxt == ST_RUN);
      end
   end

   assign ext_irq_req = ext_irq_req_r;
   assign nmi_req = nmi_req_r;
   assign irq_service_ack = irq_service_ack_r;
   assign serviced_irq_number = serviced_irq_number_r;
   assign deep_sleep_status = deep_sleep_status_r;
   assign cpu_run = cpu_run_r;

endmodule

// ### design/pin_edge_sync.v
/*
 Three-stage pin synchroniser with a stable level and registered
 one-cycle rise and fall pulses.
 Assumes the pin is asynchronous to clock and that any level it
 shows is held for at least three clock cycles.
*/
`timescale 1ns/1ns
`include "ext_irq_defs.vh"

module pin_edge_sync (
   // Clock and reset
   input wire clock,
   input wire reset_n,
   // Asynchronous pin
   input wire pin,
   // Synchronised results
   output wire level,
   output wire rise,
   output wire fall
);

   reg meta_r;
   reg s2_r;
   reg s3_r;
   reg stable_r;
   reg rise_r;
   reg fall_r;
   wire agree;

   // A change counts only once the second and third stages agree
   assign agree = (s2_r == s3_r);

   // Synchroniser chain; the first stage feeds only the second
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         meta_r <= `SYNC_RESET_LEVEL;
         s2_r <= `SYNC_RESET_LEVEL;
         s3_r <= `SYNC_RESET_LEVEL;
      end else begin
         meta_r <= pin;
         s2_r <= meta_r;
         s3_r <= s2_r;
      end
   end

   // Stable level and edge pulses, each edge reported exactly once
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         stable_r <= `SYNC_RESET_LEVEL;
         rise_r <= 1'b0;
         fall_r <= 1'b0;
      end else begin
         rise_r <= agree & s3_r & ~stable_r;
         fall_r <= agree & ~s3_r & stable_r;
         if (agree) begin
            stable_r <= s3_r;
         end
      end
   end

   assign level = stable_r;
   assign rise = rise_r;
   assign fall = fall_r;

endmodule

// ### tb/ext_interrupt_pin_interface_test.sv
/* Self-checking bench for the interrupt pin interface.
 Assumes design files, checker and source model compiled. */
`timescale 1ns/1ns
module ext_interrupt_pin_interface_test;
   reg clock = 1'b0;
   reg reset_n = 1'b0;
   reg [3:0] pol;
   reg [3:0] en;
   reg strobe;
   reg [3:0] vec;
   reg pd_go;
   reg [1:0] pd_mode;
   wire [4:0] pins;
   wire [3:0] req;
   wire [3:0] num;
   wire nmi_req, ack, deep, run;
   integer err_count = 0;
   integer n_checks = 0;
   integer cycles = 0;
   integer i;
   // 25 MHz core clock
   always #20 clock = ~clock;
   irq_sources i_src (.pins(pins));
   ext_irq_pin_interface i_dut (.clock(clock), .reset_n(reset_n), .ext_irq_in_a(pins[0]),
      .ext_irq_in_b(pins[1]), .ext_irq_in_c(pins[2]), .ext_irq_in_d(pins[3]), .nmi_in(pins[4]),
      .ext_irq_polarity_sel(pol), .ext_irq_enable(en), .cpu_service_strobe(strobe),
      .cpu_service_vector(vec), .pd_enter_strobe(pd_go), .pd_enter_mode(pd_mode), .ext_irq_req(req),
      .nmi_req(nmi_req), .irq_service_ack(ack), .serviced_irq_number(num), .deep_sleep_status(deep),
      .cpu_run(run));
   // Hang guard, well beyond the few hundred cycles needed
   always @(posedge clock) begin
      cycles = cycles + 1;
      if (cycles == 4000) begin
         err_count = err_count + 1;
         give_verdict;
      end
   end
   task give_verdict;
      begin
         if (err_count == 0 && n_checks > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   task chk(input [63:0] name, input [3:0] seen, input [3:0] exp);
      begin
         n_checks = n_checks + 1;
         if (seen !== exp) begin
            err_count = err_count + 1;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
         end
      end
   endtask
   task tick(input integer n);
      repeat (n) @(negedge clock);
   endtask
   task do_reset;
      begin
         reset_n = 1'b0;
         tick(16);
         reset_n = 1'b1;
      end
   endtask
   // One-cycle strobes from the core
   task svc(input [3:0] v);
      begin
         strobe = 1'b1;
         vec = v;
         tick(1);
         strobe = 1'b0;
      end
   endtask
   task pd(input [1:0] m);
      begin
         pd_go = 1'b1;
         pd_mode = m;
         tick(1);
         pd_go = 1'b0;
      end
   endtask
   // Each input in both polarities, the rising edge checked as ignored under falling polarity
   task t_ext;
      for (i = 0; i < 4; i = i + 1) begin
         pol = 4'h0;
         i_src.set_pins(5'h01 << i);
         tick(6);
         chk("rise", req, 4'h1 << i);
         svc({2'h1, i[1:0]});
         chk("ack", {3'h0, ack}, 4'h1);
         chk("num", num, {2'h1, i[1:0]});
         tick(1);
         chk("clear", req, 4'h0);
         pol[i] = 1'b1;
         i_src.set_pins(5'h00);
         tick(6);
         chk("fall", req, 4'h1 << i);
         svc({2'h1, i[1:0]});
         i_src.set_pins(5'h01 << i);
         tick(6);
         chk("ignore", req, 4'h0);
         pol = 4'h0;
         i_src.set_pins(5'h00);
         tick(6);
      end
   endtask
   // Nonmaskable input ignores the mask and falling edges; a masked input keeps its flag
   task t_nmi;
      begin
         en = 4'h0;
         i_src.set_pins(5'h11);
         tick(6);
         chk("nmi", {3'h0, nmi_req}, 4'h1);
         chk("masked", req, 4'h0);
         svc(4'h1);
         chk("nmi num", num, 4'h1);
         i_src.set_pins(5'h00);
         tick(6);
         chk("nmi fall", {3'h0, nmi_req}, 4'h0);
         en = 4'hf;
         tick(1);
         chk("unmasked", req, 4'h1);
         svc(4'h4);
         tick(1);
         chk("unm clr", req, 4'h0);
      end
   endtask
   // Back-to-back services of every vector, internal ones too
   task t_vecs;
      begin
         strobe = 1'b1;
         for (i = 0; i < 16; i = i + 1) begin
            vec = i[3:0];
            tick(1);
            chk("b2b ack", {3'h0, ack}, 4'h1);
            chk("b2b num", num, i[3:0]);
         end
         strobe = 1'b0;
         tick(2);
         chk("hold", num, 4'hf);
         chk("ack end", {3'h0, ack}, 4'h0);
      end
   endtask
   // Power-down modes: mode 1 wakes, 2 and 3 hold status until reset
   task t_power;
      begin
         pd(2'h0);
         chk("mode0", {3'h0, run}, 4'h1);
         pd(2'h1);
         chk("m1 pd", {2'h0, deep, run}, 4'h0);
         svc(4'h9);
         chk("m1 ack", {3'h0, ack}, 4'h0);
         i_src.set_pins(5'h01);
         tick(7);
         chk("wake", {2'h0, deep, run}, 4'h1);
         svc(4'h4);
         i_src.set_pins(5'h00);
         for (i = 2; i < 4; i = i + 1) begin
            pd(i[1:0]);
            tick(5);
            chk("deep", {2'h0, deep, run}, 4'h2);
            do_reset;
            tick(1);
            chk("deep rst", {2'h0, deep, run}, 4'h1);
         end
      end
   endtask
   initial begin
      pol = 4'h0;
      en = 4'hf;
      strobe = 1'b0;
      vec = 4'h0;
      pd_go = 1'b0;
      pd_mode = 2'h0;
      do_reset;
      tick(1);
      t_ext;
      t_nmi;
      t_vecs;
      t_power;
      give_verdict;
   end
endmodule
bind ext_irq_pin_interface ext_irq_checker i_chk (.clock(clock), .reset_n(reset_n),
   .ext_irq_enable(ext_irq_enable), .cpu_service_strobe(cpu_service_strobe),
   .cpu_service_vector(cpu_service_vector), .pd_enter_strobe(pd_enter_strobe),
   .pd_enter_mode(pd_enter_mode), .ext_irq_req(ext_irq_req), .nmi_req(nmi_req),
   .irq_service_ack(irq_service_ack), .serviced_irq_number(serviced_irq_number),
   .deep_sleep_status(deep_sleep_status), .cpu_run(cpu_run));

// ### tb/ext_irq_checker_assertions.sv
/* Port assertions for the interrupt pin interface.
 Assumes a bind onto ext_irq_pin_interface. */
`timescale 1ns/1ns
module ext_irq_checker (
   // Clock and reset
   input wire clock,
   input wire reset_n,
   // Core side
   input wire [3:0] ext_irq_enable,
   input wire cpu_service_strobe,
   input wire [3:0] cpu_service_vector,
   input wire pd_enter_strobe,
   input wire [1:0] pd_enter_mode,
   // Outputs watched
   input wire [3:0] ext_irq_req,
   input wire nmi_req,
   input wire irq_service_ack,
   input wire [3:0] serviced_irq_number,
   input wire deep_sleep_status,
   input wire cpu_run
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (!reset_n);
   // Requests only count while the core runs
   wire svc = cpu_service_strobe && cpu_run;
   wire dive = pd_enter_strobe && cpu_run;
   a_ack_pulse: assert property (svc |=> irq_service_ack) else $error("ack missing");
   a_ack_cause: assert property (irq_service_ack |-> $past(svc)) else $error("stray ack");
   a_num_index: assert property (svc |=> serviced_irq_number == $past(cpu_service_vector))
      else $error("number wrong");
   a_num_hold: assert property (!irq_service_ack |-> $stable(serviced_irq_number))
      else $error("number moved");
   a_deep_set: assert property (dive && pd_enter_mode[1] |=> deep_sleep_status) else $error("no deep");
   a_light_mode: assert property (dive && pd_enter_mode == 2'h1 |=> !deep_sleep_status && !cpu_run)
      else $error("mode one wrong");
   a_deep_stay: assert property (deep_sleep_status |=> deep_sleep_status && !cpu_run)
      else $error("deep left");
   a_nmi_keep: assert property (nmi_req && !(svc && cpu_service_vector == 4'h1) |=> nmi_req)
      else $error("nmi lost");
   a_ext_mask: assert property ((ext_irq_req & ~$past(ext_irq_enable)) == 4'h0)
      else $error("masked req");
endmodule

// ### tb/irq_sources.sv
/* External interrupt sources driving five pins.
 Assumes the bench changes levels after a falling edge. */
`timescale 1ns/1ns
module irq_sources (
   // Pins a..d then nonmaskable
   output reg [4:0] pins
);
   // Levels are held at least three cycles, or edges may be lost
   initial pins = 5'h00;
   task set_pins(input [4:0] v);
      pins = v;
   endtask
endmodule
